// [logic/dpsem_params.svh]
// timing counts and field constants for the token host controller
`ifndef DPSEM_PARAMS_SVH
`define DPSEM_PARAMS_SVH
`define DPSEM_FLAG_COUNT 8
`define DPSEM_IDX_W 3
`define DPSEM_DATA_W 16
`define DPSEM_CLK_MHZ 200
`define DPSEM_SETUP_NS 20
`define DPSEM_SETUP_CYC ((`DPSEM_SETUP_NS * `DPSEM_CLK_MHZ + 999) / 1000)
`define DPSEM_CLAIM_DATA 1'b0
`define DPSEM_FREE_DATA 1'b1
`endif

// [logic/dpsem_pkg.sv]
// types for the token host controller
package dpsem_pkg;
    typedef enum logic [1:0] {
        DPSEM_OP_CLAIM,
        DPSEM_OP_RELEASE,
        DPSEM_OP_POLL,
        DPSEM_OP_INIT
    } dpsem_op_e;
    typedef enum logic [2:0] {
        DPSEM_IDLE,
        DPSEM_WRITE,
        DPSEM_GAP,
        DPSEM_READ,
        DPSEM_DONE
    } dpsem_state_e;
endpackage

// [logic/dpsem_host.sv]
// host controller driving one port of a dual-port token flag block
`timescale 1ns/1ps
`default_nettype none
`include "dpsem_params.svh"
module dpsem_host
    import dpsem_pkg::*;
#(
    parameter int SETUP_CYC = `DPSEM_SETUP_CYC,
    parameter int DATA_W = `DPSEM_DATA_W
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire dpsem_op_e cmd_op,
    input wire logic [`DPSEM_IDX_W-1:0] cmd_index,
    output logic rsp_valid,
    output logic rsp_owned,
    output logic rsp_flag,
    output logic init_done,
    output logic token_space_select_n,
    output logic output_enable_n,
    output logic write_enable_n,
    output logic [`DPSEM_IDX_W-1:0] token_index_bits,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe_n,
    input wire logic [DATA_W-1:0] data_in
);
    // below two cycles the write strobe would vanish inside select and the
    // read would be taken before the synchroniser holds the device's data
    localparam int PHASE_CYC = (SETUP_CYC < 2) ? 2 : SETUP_CYC;
    localparam logic [7:0] SETUP_LAST = 8'(PHASE_CYC - 1);
    localparam logic [7:0] READ_LAST = 8'(PHASE_CYC + 1);

    dpsem_state_e state;
    dpsem_op_e op;
    logic [7:0] wait_cnt;
    logic [`DPSEM_IDX_W-1:0] init_idx;
    logic init_busy;
    logic [DATA_W-1:0] din_meta;
    logic [DATA_W-1:0] din_sync;
    logic wr_bit;

    // an unsynced bus from another device; a whole-word read is safe because
    // the device holds it frozen while this port keeps its read active
    always_ff @(posedge sys_clk) begin
        din_meta <= data_in;
        din_sync <= din_meta;
    end

    function automatic logic flag_of(input logic [DATA_W-1:0] w);
        flag_of = &w;
    endfunction

    // shared by the write and gap phases
    function automatic logic [7:0] next_phase_cnt(input logic [7:0] cnt, input logic last);
        next_phase_cnt = last ? 8'h00 : cnt + 8'h01;
    endfunction

    assign cmd_ready = (state == DPSEM_IDLE) && !init_busy;
    wire logic phase_end = (wait_cnt == SETUP_LAST);
    // last read cycle: the synchronised word is taken here
    wire logic read_last = (state == DPSEM_READ) && (wait_cnt == READ_LAST);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state <= DPSEM_IDLE;
            wait_cnt <= 8'h00;
        end else begin
            unique case (state)
                DPSEM_IDLE: begin
                    wait_cnt <= 8'h00;
                    if (init_busy || cmd_valid) begin
                        // polls skip the write: reads never claim
                        state <= (!init_busy && cmd_op == DPSEM_OP_POLL) ?
                            DPSEM_READ : DPSEM_WRITE;
                    end
                end
                DPSEM_WRITE: begin
                    wait_cnt <= next_phase_cnt(wait_cnt, phase_end);
                    if (phase_end) begin
                        state <= DPSEM_GAP;
                    end
                end
                DPSEM_GAP: begin
                    wait_cnt <= next_phase_cnt(wait_cnt, phase_end);
                    if (phase_end) begin
                        state <= (op == DPSEM_OP_CLAIM) ? DPSEM_READ : DPSEM_DONE;
                    end
                end
                DPSEM_READ: begin
                    // two extra cycles cover the input synchroniser
                    wait_cnt <= wait_cnt + 8'h01;
                    if (read_last) begin
                        state <= DPSEM_DONE;
                    end
                end
                DPSEM_DONE: begin
                    wait_cnt <= 8'h00;
                    state <= DPSEM_IDLE; // strobes off for at least two cycles
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            op <= DPSEM_OP_INIT;
            token_index_bits <= 3'h0;
            wr_bit <= `DPSEM_FREE_DATA;
        end else if (state == DPSEM_IDLE) begin
            if (init_busy) begin
                op <= DPSEM_OP_INIT;
                token_index_bits <= init_idx;
                wr_bit <= `DPSEM_FREE_DATA;
            end else if (cmd_valid) begin
                op <= cmd_op;
                token_index_bits <= cmd_index;
                // a failed claim stays pending; only a release, an init command or the start-up sweep withdraws it
                // a release also withdraws a pending request
                wr_bit <= (cmd_op == DPSEM_OP_CLAIM) ? `DPSEM_CLAIM_DATA :
                    `DPSEM_FREE_DATA;
            end
        end
    end

    // start-up sweep frees every flag from this port; the far port does its own
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            init_busy <= 1'b1;
            init_idx <= 3'h0;
            init_done <= 1'b0;
        end else if (state == DPSEM_DONE && op == DPSEM_OP_INIT) begin
            init_idx <= init_idx + 3'h1;
            if (init_idx == 3'(`DPSEM_FLAG_COUNT - 1)) begin
                init_busy <= 1'b0;
                init_done <= 1'b1;
            end
        end
    end

    // index is stable a full cycle before select asserts
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            token_space_select_n <= 1'b1;
        end else begin
            token_space_select_n <= !(state == DPSEM_WRITE || state == DPSEM_READ);
        end
    end

    // the strobe rises a cycle before select so the device latches a settled bit
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            write_enable_n <= 1'b1;
        end else begin
            write_enable_n <= !(state == DPSEM_WRITE && !phase_end);
        end
    end

    // data stays driven through the gap to cover the device's hold time
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            data_out <= '0;
            data_oe_n <= 1'b1;
        end else begin
            data_oe_n <= !(state == DPSEM_WRITE || state == DPSEM_GAP);
            data_out <= {{(DATA_W-1){1'b0}}, wr_bit};
        end
    end

    // select and enable fall together so the device latches one settled read
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            output_enable_n <= 1'b1;
        end else begin
            output_enable_n <= !(state == DPSEM_READ);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rsp_valid <= 1'b0;
        end else begin
            rsp_valid <= (state == DPSEM_DONE) && (op != DPSEM_OP_INIT);
        end
    end

    // ownership after a claim or poll is read back; a release answers not owned without a read
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rsp_owned <= 1'b0;
            rsp_flag <= 1'b1;
        end else if (read_last) begin
            rsp_flag <= flag_of(din_sync);
            rsp_owned <= !flag_of(din_sync);
        end else if (state == DPSEM_DONE && op == DPSEM_OP_RELEASE) begin
            rsp_flag <= 1'b1;
            rsp_owned <= 1'b0;
        end
    end
    // flags are purely advisory here; no memory access is gated
endmodule
`default_nettype wire

// [verification/dpsem_host_monitor.sv]
// checker for the token host controller pin and answer timing
`timescale 1ns/1ps
`default_nettype none
`include "dpsem_params.svh"
module dpsem_host_monitor
    import dpsem_pkg::*;
#(parameter int SETUP_CYC = 4, parameter int DATA_W = 16) (
    input wire logic sys_clk, input wire logic srst,
    input wire logic cmd_valid, input wire logic cmd_ready,
    input wire dpsem_op_e cmd_op, input wire logic [`DPSEM_IDX_W-1:0] cmd_index,
    input wire logic rsp_valid, input wire logic rsp_owned,
    input wire logic rsp_flag, input wire logic init_done,
    input wire logic token_space_select_n, input wire logic output_enable_n,
    input wire logic write_enable_n, input wire logic [`DPSEM_IDX_W-1:0] token_index_bits,
    input wire logic [DATA_W-1:0] data_out, input wire logic data_oe_n,
    input wire logic [DATA_W-1:0] data_in
);
    localparam int PHASE_CYC = (SETUP_CYC < 2) ? 2 : SETUP_CYC;
    localparam int POLL_LAT = PHASE_CYC + 4;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    sequence s_poll; cmd_valid && cmd_ready && cmd_op == DPSEM_OP_POLL; endsequence
    sequence s_claim_wr; $fell(write_enable_n) && !data_out[0]; endsequence
    sequence s_read; !output_enable_n && !token_space_select_n; endsequence
    property p_wsel; !write_enable_n |-> !token_space_select_n; endproperty
    property p_rw; write_enable_n || output_enable_n; endproperty
    property p_drv; !write_enable_n |-> !data_oe_n; endproperty
    property p_d0; data_out[DATA_W-1:1] == '0; endproperty
    property p_gap; $rose(token_space_select_n) |-> token_space_select_n [*2]; endproperty
    property p_poll; s_poll |-> ##[POLL_LAT:POLL_LAT] rsp_valid; endproperty
    property p_claim; s_claim_wr |-> ##[1:60] s_read; endproperty
    property p_rsp; rsp_valid |-> rsp_owned != rsp_flag; endproperty
    property p_rdy; !init_done |-> !cmd_ready; endproperty
    property p_idx; !token_space_select_n |-> $stable(token_index_bits); endproperty
    a_wsel: assert property (p_wsel) else $error("write outside select");
    a_rw: assert property (p_rw) else $error("read and write together");
    a_drv: assert property (p_drv) else $error("data not driven on write");
    a_d0: assert property (p_d0) else $error("upper data bits set");
    a_gap: assert property (p_gap) else $error("select gap too short");
    a_poll: assert property (p_poll) else $error("poll answer off time");
    a_claim: assert property (p_claim) else $error("claim without readback");
    a_rsp: assert property (p_rsp) else $error("owned and flag disagree");
    a_rdy: assert property (p_rdy) else $error("ready before sweep");
    a_idx: assert property (p_idx) else $error("index moved inside select");
endmodule
bind dpsem_host dpsem_host_monitor #(.SETUP_CYC(SETUP_CYC), .DATA_W(DATA_W)) i_mon (
    .sys_clk, .srst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_index, .rsp_valid, .rsp_owned,
    .rsp_flag, .init_done, .token_space_select_n, .output_enable_n, .write_enable_n,
    .token_index_bits, .data_out, .data_oe_n, .data_in);
`default_nettype wire

// [verification/dpsem_dev.sv]
// behavioural two-port token flag device; far port is a simple write strobe
`timescale 1ns/1ps
`default_nettype none
module dpsem_dev (
    input wire logic sel_n, input wire logic oe_n, input wire logic we_n,
    input wire logic [2:0] idx, input wire logic [15:0] din, output logic [15:0] dout,
    input wire logic o_we, input wire logic [2:0] o_idx, input wire logic o_val,
    output logic o_flag
);
    // power-up junk: half held by each side, every latch requesting
    logic [7:0] rq_h = 8'h00, rq_o = 8'h00, own_h = 8'h0f, own_o = 8'hf0;
    logic q;
    task automatic wr(input bit h, input logic [2:0] i, input logic v);
        logic po, ps;
        if (h) rq_h[i] = v; else rq_o[i] = v;
        own_h[i] = own_h[i] & !rq_h[i];
        own_o[i] = own_o[i] & !rq_o[i];
        po = h ? !rq_o[i] : !rq_h[i];
        ps = h ? !rq_h[i] : !rq_o[i];
        // an earlier pending request beats the writer
        if (!own_h[i] && !own_o[i] && (po || ps)) begin
            if (h == po) own_o[i] = 1'b1; else own_h[i] = 1'b1;
        end
    endtask
    always @(posedge we_n) if (!sel_n) wr(1'b1, idx, din[0]);
    always @(posedge o_we) wr(1'b0, o_idx, o_val);
    always @(negedge sel_n or negedge oe_n) if (!sel_n && !oe_n) q = !own_h[idx];
    // released bus shows the inverse so a stale value never passes
    assign dout = (!sel_n && !oe_n) ? {16{q}} : {16{!q}};
    // no memory array is modelled, so the flags can gate nothing
    assign o_flag = !own_o[o_idx];
endmodule
`default_nettype wire

// [verification/dpsem_host_tb.sv]
// testbench for the token host controller against the flag device model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
    $display("Error %0t: got %b want %b", $time, a, b); end end
module dpsem_host_tb;
    import dpsem_pkg::*;
    logic sys_clk = 1'b0, srst = 1'b1, cmd_valid = 1'b0, cmd_ready, rsp_valid, rsp_owned;
    logic rsp_flag, init_done, sel_n, oe_n, we_n, doe_n, o_we = 1'b0, o_val = 1'b1, o_flag;
    dpsem_op_e cmd_op = DPSEM_OP_POLL;
    logic [2:0] cmd_index = 3'h0, idx, o_idx = 3'h0;
    logic [15:0] dout, din;
    int n_fail = 0, checks_done = 0;
    always #2.5 sys_clk = ~sys_clk;
    dpsem_host #(.SETUP_CYC(1)) i_dpsem_host (.sys_clk(sys_clk), .srst(srst),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_index(cmd_index),
        .rsp_valid(rsp_valid), .rsp_owned(rsp_owned), .rsp_flag(rsp_flag),
        .init_done(init_done), .token_space_select_n(sel_n), .output_enable_n(oe_n),
        .write_enable_n(we_n), .token_index_bits(idx), .data_out(dout), .data_oe_n(doe_n),
        .data_in(din));
    dpsem_dev i_dpsem_dev (.sel_n(sel_n), .oe_n(oe_n), .we_n(we_n), .idx(idx), .din(dout),
        .dout(din), .o_we(o_we), .o_idx(o_idx), .o_val(o_val), .o_flag(o_flag));
    task automatic cmd(input dpsem_op_e op, input logic [2:0] i, input logic eo);
        int n = 0;
        cmd_op <= op;
        cmd_index <= i;
        cmd_valid <= 1'b1;
        do @(posedge sys_clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        do begin @(posedge sys_clk); n++; end while (rsp_valid !== 1'b1 && n < 60);
        `CHK(rsp_valid, 1'b1)
        `CHK(rsp_owned, eo)
        `CHK(rsp_flag, !eo)
    endtask
    task automatic owr(input logic [2:0] i, input logic v);
        o_idx <= i;
        o_val <= v;
        o_we <= 1'b1;
        @(posedge sys_clk) o_we <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic t_sweep();
        int n = 0;
        while (init_done !== 1'b1 && n < 200) begin @(posedge sys_clk); n++; end
        `CHK(init_done, 1'b1)
        for (int i = 0; i < 8; i++) owr(3'(i), 1'b1);
        for (int i = 0; i < 8; i++) cmd(DPSEM_OP_POLL, 3'(i), 1'b0);
    endtask
    task automatic t_pass();
        o_idx <= 3'h5;
        cmd(DPSEM_OP_CLAIM, 3'h5, 1'b1);
        `CHK(o_flag, 1'b1)
        owr(3'h5, 1'b0);
        cmd(DPSEM_OP_POLL, 3'h5, 1'b1);
        cmd(DPSEM_OP_RELEASE, 3'h5, 1'b0);
        `CHK(o_flag, 1'b0)
        cmd(DPSEM_OP_CLAIM, 3'h5, 1'b0);
        owr(3'h5, 1'b1);
        cmd(DPSEM_OP_POLL, 3'h5, 1'b1);
        cmd(DPSEM_OP_RELEASE, 3'h5, 1'b0);
        o_idx <= 3'h2;
        cmd(DPSEM_OP_CLAIM, 3'h2, 1'b1);
        `CHK(o_flag, 1'b1)
    endtask
    task automatic final_report();
        if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge sys_clk);
        srst <= 1'b0;
        t_sweep();
        t_pass();
        final_report();
    end
    initial begin
        #20000;
        n_fail++;
        final_report();
    end
endmodule
`default_nettype wire
